/* File: src/vbc_pkg.sv */
// package: constants and carrier types for supply control and charger detect
package vbc_pkg;

    // ---------------------------------------------------------------
    // register bit positions
    // ---------------------------------------------------------------
    localparam int IFC_INVERT_BIT   = 5;
    localparam int IFC_BYPASS_BIT   = 6;
    localparam int OTG_EXT_SEL_BIT  = 7;
    localparam int OTG_DRIVE_BIT     = 5;
    localparam int OTG_DRIVE_ALT_BIT = 6;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] IFC_RESET = 8'h00;
    localparam logic [7:0] OTG_RESET = 8'h00;
    localparam logic [2:0] REG_LEVEL_RESET = 3'h0;
    localparam logic [1:0] LINE_SE0 = 2'h0;

    // ---------------------------------------------------------------
    // carrier types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic data_voltage_source_en;
        logic data_current_sink_en;
        logic contact_detect_en;
        logic host_charge_en;
        logic plus_line_pulldown;
        logic minus_line_pulldown;
    } vbc_chg_en_t;

    typedef struct packed {
        logic sel;
        logic bypass;
        logic invert;
    } vbc_ind_cfg_t;

endpackage : vbc_pkg

/* File: src/vbc_sync_flag.sv */
// sticky change flag: set on a level change, cleared by the link
`timescale 1ns/1ns
`default_nettype none
module vbc_sync_flag (
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    input  wire logic level_in,
    input  wire logic clear_in,
    output logic      flag_out
);
    logic level_q_r;
    logic flag_r;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            level_q_r <= 1'b0;
        end else begin
            level_q_r <= level_in;
        end
    end

    // set wins over clear so no change is lost
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flag_r <= 1'b0;
        end else if (level_in != level_q_r) begin
            flag_r <= 1'b1;
        end else if (clear_in) begin
            flag_r <= 1'b0;
        end
    end

    assign flag_out = flag_r;
endmodule // vbc_sync_flag
`default_nettype wire

/* File: src/vbc_top.sv */
// top: supply switch drive, supply-valid source select, uart and charger detect
`timescale 1ns/1ns
`default_nettype none
module vbc_top (
    // clock and reset
    input  wire logic                  CLK_IN,
    input  wire logic                  RESET_N_IN,
    // register bits from the link
    input  wire logic [7:0]            IFC_CTRL_IN,
    input  wire logic [7:0]            OTG_CTRL_IN,
    input  wire logic                  OTG_WR_IN,
    input  wire logic                  IFC_WR_IN,
    input  wire logic [2:0]            UART_LEVEL_IN,
    input  wire logic [2:0]            NORMAL_LEVEL_IN,
    input  wire logic                  UART_MODE_IN,
    input  wire logic                  LOW_POWER_IN,
    input  wire vbc_pkg::vbc_chg_en_t  CHG_EN_IN,
    input  wire logic                  DET_IRQ_CLR_IN,
    // analog and pin levels
    input  wire logic                  SUPPLY_VALID_COMPARE_IN,
    input  wire logic                  EXT_SENSE_IN,
    input  wire logic                  DATA_VOLTAGE_RAW_IN,
    input  wire logic [1:0]            LINE_STATE_IN,
    // outputs
    output logic                       SWITCH_EN_N_OUT,
    output logic                       SWITCH_EN_N_OE_N_OUT,
    output logic                       SUPPLY_VALID_OUT,
    output logic                       SENSE_PULLDOWN_OUT,
    output logic [2:0]                 REG_LEVEL_OUT,
    output logic [1:0]                 LINE_STATE_OUT,
    output vbc_pkg::vbc_chg_en_t       CHG_EN_OUT,
    output logic                       DATA_VOLTAGE_DETECT_OUT,
    output logic                       DET_IRQ_OUT
);
    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    logic                  drive_r;
    logic                  drive_alt_r;
    vbc_pkg::vbc_ind_cfg_t cfg_r;
    logic                  switch_n_r;
    logic                  valid_r;
    logic                  pd_r;
    logic [2:0]            level_r;
    logic [1:0]            line_r;
    vbc_pkg::vbc_chg_en_t  chg_r;
    logic                  det_r;
    logic                  det_nxt;
    logic                  valid_nxt;
    logic                  irq_flag;

    // one process owns the whole option struct; async clear is power-on
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            drive_r      <= 1'b0;
            drive_alt_r  <= 1'b0;
            cfg_r.sel    <= vbc_pkg::OTG_RESET[vbc_pkg::OTG_EXT_SEL_BIT];
            cfg_r.bypass <= vbc_pkg::IFC_RESET[vbc_pkg::IFC_BYPASS_BIT];
            cfg_r.invert <= vbc_pkg::IFC_RESET[vbc_pkg::IFC_INVERT_BIT];
        end else begin
            if (OTG_WR_IN) begin
                drive_r     <= OTG_CTRL_IN[vbc_pkg::OTG_DRIVE_BIT];
                drive_alt_r <= OTG_CTRL_IN[vbc_pkg::OTG_DRIVE_ALT_BIT];
                cfg_r.sel   <= OTG_CTRL_IN[vbc_pkg::OTG_EXT_SEL_BIT];
            end
            if (IFC_WR_IN) begin
                cfg_r.bypass <= IFC_CTRL_IN[vbc_pkg::IFC_BYPASS_BIT];
                cfg_r.invert <= IFC_CTRL_IN[vbc_pkg::IFC_INVERT_BIT];
            end
        end
    end

    // ---------------------------------------------------------------
    // supply switch and supply-valid source
    // ---------------------------------------------------------------
    always_comb begin
        if (!cfg_r.sel) begin
            valid_nxt = SUPPLY_VALID_COMPARE_IN;
        end else if (cfg_r.bypass) begin
            valid_nxt = EXT_SENSE_IN ^ cfg_r.invert;
        end else begin
            valid_nxt = (EXT_SENSE_IN ^ cfg_r.invert) & SUPPLY_VALID_COMPARE_IN;
        end
    end

    // open drain: pin is driven (oe_n low) only while pulling low
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            switch_n_r <= 1'b1;
            valid_r    <= 1'b0;
            pd_r       <= 1'b1;
        end else begin
            switch_n_r <= ~(drive_r | drive_alt_r);
            valid_r    <= valid_nxt;
            pd_r       <= ~cfg_r.sel;
        end
    end

    // ---------------------------------------------------------------
    // uart side effects
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            level_r <= vbc_pkg::REG_LEVEL_RESET;
            line_r  <= vbc_pkg::LINE_SE0;
        end else begin
            level_r <= UART_MODE_IN ? UART_LEVEL_IN : NORMAL_LEVEL_IN;
            line_r  <= UART_MODE_IN ? vbc_pkg::LINE_SE0 : LINE_STATE_IN;
        end
    end

    // ---------------------------------------------------------------
    // charger detect: runs regardless of low power
    // ---------------------------------------------------------------
    assign det_nxt = DATA_VOLTAGE_RAW_IN & (LINE_STATE_IN == vbc_pkg::LINE_SE0);

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            chg_r <= '0;
            det_r <= 1'b0;
        end else begin
            chg_r <= CHG_EN_IN;
            det_r <= det_nxt;
        end
    end

    vbc_sync_flag vbc_sync_flag_inst (
        .clk_in     (CLK_IN),
        .reset_n_in (RESET_N_IN),
        .level_in   (det_r),
        .clear_in   (DET_IRQ_CLR_IN),
        .flag_out   (irq_flag)
    );

    assign SWITCH_EN_N_OUT         = switch_n_r;
    assign SWITCH_EN_N_OE_N_OUT    = switch_n_r;
    assign SUPPLY_VALID_OUT        = valid_r;
    assign SENSE_PULLDOWN_OUT      = pd_r;
    assign REG_LEVEL_OUT           = level_r;
    assign LINE_STATE_OUT          = line_r;
    assign CHG_EN_OUT              = chg_r;
    assign DATA_VOLTAGE_DETECT_OUT = det_r;
    assign DET_IRQ_OUT             = irq_flag;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence s_req_seen;
        drive_r || drive_alt_r;
    endsequence

    sequence s_se0_low_power;
        LOW_POWER_IN && DATA_VOLTAGE_RAW_IN && (LINE_STATE_IN == vbc_pkg::LINE_SE0);
    endsequence

    a_switch_nor: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        s_req_seen |=> !SWITCH_EN_N_OUT && !SWITCH_EN_N_OE_N_OUT)
        else $error("switch enable not driven low");
    a_switch_idle: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        !drive_r && !drive_alt_r |=> SWITCH_EN_N_OUT)
        else $error("switch enable active without request");
    a_valid_int: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        !cfg_r.sel |=> SUPPLY_VALID_OUT == $past(SUPPLY_VALID_COMPARE_IN))
        else $error("internal comparator not reported");
    a_valid_pass: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        cfg_r.sel && cfg_r.bypass |=> SUPPLY_VALID_OUT == ($past(EXT_SENSE_IN) ^ $past(cfg_r.invert)))
        else $error("bypass value wrong");
    a_valid_qual: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        cfg_r.sel && !cfg_r.bypass && !SUPPLY_VALID_COMPARE_IN |=> !SUPPLY_VALID_OUT)
        else $error("qualified value not gated");
    a_pulldown_sel: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        cfg_r.sel |=> !SENSE_PULLDOWN_OUT)
        else $error("pull-down left on");
    a_uart_level: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        UART_MODE_IN |=> REG_LEVEL_OUT == $past(UART_LEVEL_IN))
        else $error("uart regulator level not applied");
    a_uart_line: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        UART_MODE_IN |=> LINE_STATE_OUT == vbc_pkg::LINE_SE0)
        else $error("line state shown in uart mode");
    a_detect_se0: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        LINE_STATE_IN != vbc_pkg::LINE_SE0 |=> !DATA_VOLTAGE_DETECT_OUT)
        else $error("detect asserted outside se0");
    a_detect_irq: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        $changed(det_r) |=> DET_IRQ_OUT)
        else $error("detect change lost");
    a_cfg_write: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        IFC_WR_IN |=> cfg_r.bypass == $past(IFC_CTRL_IN[vbc_pkg::IFC_BYPASS_BIT])
            && cfg_r.invert == $past(IFC_CTRL_IN[vbc_pkg::IFC_INVERT_BIT]))
        else $error("indicator options not taken");
    a_sel_write: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        OTG_WR_IN |=> cfg_r.sel == $past(OTG_CTRL_IN[vbc_pkg::OTG_EXT_SEL_BIT]))
        else $error("external select not taken");
    a_pulldown_idle: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        !cfg_r.sel |=> SENSE_PULLDOWN_OUT)
        else $error("pull-down not connected");
    a_detect_lowpwr: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        s_se0_low_power |=> DATA_VOLTAGE_DETECT_OUT)
        else $error("detect stalled in low power");
    a_irq_hold: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        DET_IRQ_OUT && !DET_IRQ_CLR_IN |=> DET_IRQ_OUT)
        else $error("detect flag dropped without clear");
    a_irq_clear: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
        DET_IRQ_CLR_IN && $stable(det_r) |=> !DET_IRQ_OUT)
        else $error("detect flag not cleared");
endmodule // vbc_top
`default_nettype wire

/* File: test/vbc_link_model.sv */
// link-side model: register writes and charger mode table
`timescale 1ns/1ns
`default_nettype none
module vbc_link_model #(
    parameter int CONNECT_TIMEOUT = 16
) (
    // clock
    input  wire logic            clk_in,
    // device status seen by the link
    input  wire logic            session_in,
    input  wire logic [1:0]      line_in,
    input  wire logic            det_in,
    // register bits towards the device
    output logic [7:0]           ifc_out,
    output logic [7:0]           otg_out,
    output logic                 ifc_wr_out,
    output logic                 otg_wr_out,
    output vbc_pkg::vbc_chg_en_t chg_out,
    // classification result
    output logic [2:0]           kind_out,
    output logic                 done_out
);
    // port classification codes and mode table indices
    localparam logic [2:0] KIND_NONE      = 3'h0;
    localparam logic [2:0] KIND_UNKNOWN   = 3'h1;
    localparam logic [2:0] KIND_STANDARD  = 3'h2;
    localparam logic [2:0] KIND_CHARGING  = 3'h3;
    localparam logic [2:0] KIND_DEDICATED = 3'h4;
    localparam int         MODE_CONNECT   = 0;
    localparam int         MODE_CHARGER   = 1;
    localparam int         MODE_ENHANCED  = 2;
    localparam int         MODE_USB       = 3;
    // ------------------------------------------------------------
    // mode table, entries 0-3 device side, 4-6 charging host
    // ------------------------------------------------------------
    vbc_pkg::vbc_chg_en_t mode_tbl [7];

    initial begin
        mode_tbl = '{6'h09, 6'h30, 6'h34, 6'h00, 6'h17, 6'h37, 6'h07};
        {ifc_out, otg_out, ifc_wr_out, otg_wr_out} = '0;
        chg_out = 6'h00;
        kind_out = KIND_NONE;
        done_out = 1'b0;
    end

    // one-cycle strobe; data stays as register contents afterwards
    task automatic wr(input logic to_otg, input logic [7:0] v);
        @(posedge clk_in);
        #1;
        if (to_otg) begin
            otg_out = v;
            otg_wr_out = 1'b1;
        end else begin
            ifc_out = v;
            ifc_wr_out = 1'b1;
        end
        @(posedge clk_in);
        #1;
        otg_wr_out = 1'b0;
        ifc_wr_out = 1'b0;
    endtask

    task automatic set_mode(input int m);
        @(posedge clk_in);
        #1;
        chg_out = mode_tbl[m];
    endtask

    task automatic tick;
        @(posedge clk_in);
        #1;
    endtask

    // detection sequencer; a standard port result means a 500mA budget
    task automatic classify;
        int n;
        n = 0;
        kind_out = KIND_NONE;
        done_out = 1'b0;
        while (session_in !== 1'b1) begin
            tick();
        end
        set_mode(MODE_CONNECT);
        while (line_in === 2'h2 && n < CONNECT_TIMEOUT) begin
            tick();
            n++;
        end
        if (line_in === 2'h2) begin
            kind_out = KIND_UNKNOWN;
        end else begin
            set_mode(MODE_CHARGER);
            tick();
            tick();
            if (det_in === 1'b0) begin
                kind_out = KIND_STANDARD;
            end else begin
                set_mode(MODE_ENHANCED);
                tick();
                tick();
                kind_out = det_in ? KIND_DEDICATED : KIND_CHARGING;
            end
        end
        set_mode(MODE_USB);
        done_out = 1'b1;
    endtask
endmodule // vbc_link_model
`default_nettype wire

/* File: test/vbc_top_bench.sv */
// testbench for the supply control and charger detect block
`timescale 1ns/1ns
`default_nettype none
module vbc_top_bench;
    logic                 clk = 1'b0;
    logic                 rst_n, uart_mode, low_pwr, irq_clr, cmp, ext, raw, e;
    logic [2:0]           uart_lvl, norm_lvl, lvl;
    logic [1:0]           ls, ls_out;
    logic [7:0]           ifc, otg;
    logic                 ifc_wr, otg_wr, sw_n, sw_oe_n, sv, pd, det, irq;
    vbc_pkg::vbc_chg_en_t chg_in, chg_out;
    int                   n_fail = 0;
    int                   total_checks = 0;
    int                   i, j;
    logic                 sess, port_on, raw_pin, done;
    logic [1:0]           port_kind;
    logic [2:0]           kind, exp_kind;

    // far-end port: 0 standard, 1 charging, 2 dedicated, 3 unknown
    assign raw_pin = port_on ? (chg_in.data_voltage_source_en
        & (port_kind == 2'h2 | (port_kind == 2'h1 & !chg_in.host_charge_en))) : raw;

    always #50 clk = ~clk;

    vbc_link_model vbc_link_model_inst (.clk_in(clk), .session_in(sess), .line_in(ls_out), .det_in(det),
        .ifc_out(ifc), .otg_out(otg), .ifc_wr_out(ifc_wr), .otg_wr_out(otg_wr), .chg_out(chg_in),
        .kind_out(kind), .done_out(done));

    vbc_top vbc_top_inst (.CLK_IN(clk), .RESET_N_IN(rst_n), .IFC_CTRL_IN(ifc), .OTG_CTRL_IN(otg),
        .OTG_WR_IN(otg_wr), .IFC_WR_IN(ifc_wr), .UART_LEVEL_IN(uart_lvl), .NORMAL_LEVEL_IN(norm_lvl),
        .UART_MODE_IN(uart_mode), .LOW_POWER_IN(low_pwr), .CHG_EN_IN(chg_in), .DET_IRQ_CLR_IN(irq_clr),
        .SUPPLY_VALID_COMPARE_IN(cmp), .EXT_SENSE_IN(ext), .DATA_VOLTAGE_RAW_IN(raw_pin),
        .LINE_STATE_IN(ls), .SWITCH_EN_N_OUT(sw_n), .SWITCH_EN_N_OE_N_OUT(sw_oe_n),
        .SUPPLY_VALID_OUT(sv), .SENSE_PULLDOWN_OUT(pd), .REG_LEVEL_OUT(lvl), .LINE_STATE_OUT(ls_out),
        .CHG_EN_OUT(chg_out), .DATA_VOLTAGE_DETECT_OUT(det), .DET_IRQ_OUT(irq));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // generous: the sequence needs well under a thousand cycles
    initial begin
        #1000000;
        n_fail++;
        give_verdict();
    end

    initial begin
        {rst_n, uart_mode, low_pwr, irq_clr, cmp, ext, raw, sess, port_on} = '0;
        port_kind = 2'h0;
        uart_lvl = 3'h5;
        norm_lvl = 3'h2;
        ls = 2'h3;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        step(1);
        chk(sw_n, 1'b1, "switch after reset");
        chk(sw_oe_n, 1'b1, "switch oe after reset");
        chk(pd, 1'b1, "pulldown after reset");
        for (i = 0; i < 4; i++) begin
            vbc_link_model_inst.wr(1'b1, {1'b0, i[1:0], 5'h00});
            step(2);
            chk(sw_n, i == 0, "switch enable");
            chk(sw_oe_n, i == 0, "switch oe");
        end
        // both requests still set: a mid-run power-on clear must release the switch
        rst_n = 1'b0;
        step(2);
        chk(sw_n, 1'b1, "switch during reset");
        rst_n = 1'b1;
        step(2);
        chk(sw_n, 1'b1, "switch after second reset");
        chk(sw_oe_n, 1'b1, "switch oe after second reset");
        // every select, bypass and invert setting against all inputs
        for (i = 0; i < 8; i++) begin
            vbc_link_model_inst.wr(1'b0, {1'b0, i[1:0], 5'h00});
            vbc_link_model_inst.wr(1'b1, {i[2], 7'h00});
            for (j = 0; j < 4; j++) begin
                {ext, cmp} = j[1:0];
                step(2);
                e = !i[2] ? cmp : i[1] ? ext ^ i[0] : (ext ^ i[0]) & cmp;
                chk(sv, e, "supply valid source");
            end
            chk(pd, !i[2], "sense pulldown");
        end
        // normal use goes back to the internal comparator; the qualified mode stays unused
        vbc_link_model_inst.wr(1'b1, 8'h00);
        uart_mode = 1'b1;
        step(3);
        chk(lvl, uart_lvl, "uart regulator level");
        chk(ls_out, vbc_pkg::LINE_SE0, "line state hidden in uart");
        uart_mode = 1'b0;
        step(3);
        chk(lvl, norm_lvl, "normal regulator level");
        chk(ls_out, ls, "line state shown");
        // low power held: detection must keep working
        low_pwr = 1'b1;
        raw = 1'b1;
        for (i = 0; i < 4; i++) begin
            ls = i[1:0];
            step(3);
            chk(det, i == 0, "detect qualified by line state");
        end
        chk(irq, 1'b1, "detect change flag");
        irq_clr = 1'b1;
        step(1);
        irq_clr = 1'b0;
        step(2);
        chk(irq, 1'b0, "flag cleared");
        // synchronous mode as well
        low_pwr = 1'b0;
        ls = 2'h0;
        step(3);
        chk(irq, 1'b1, "flag set again");
        // clear held while detect falls: the change must win
        irq_clr = 1'b1;
        ls = 2'h3;
        step(2);
        irq_clr = 1'b0;
        step(1);
        chk(irq, 1'b1, "set wins over clear");
        for (i = 0; i < 7; i++) begin
            vbc_link_model_inst.set_mode(i);
            step(2);
            chk(chg_out, vbc_link_model_inst.mode_tbl[i], "charger enables");
        end
        // link-side classification against each kind of far-end port
        raw = 1'b0;
        sess = 1'b1;
        port_on = 1'b1;
        for (i = 0; i < 4; i++) begin
            port_kind = i[1:0];
            ls = (i == 3) ? 2'h2 : 2'h0;
            vbc_link_model_inst.classify();
            step(2);
            case (i)
                0: exp_kind = vbc_link_model_inst.KIND_STANDARD;
                1: exp_kind = vbc_link_model_inst.KIND_CHARGING;
                2: exp_kind = vbc_link_model_inst.KIND_DEDICATED;
                default: exp_kind = vbc_link_model_inst.KIND_UNKNOWN;
            endcase
            chk(done, 1'b1, "classification done");
            chk(kind, exp_kind, "port kind");
            chk(chg_out, 8'h00, "enables off for usb traffic");
        end
        give_verdict();
    end
endmodule // vbc_top_bench
`default_nettype wire
